// ---- bench/dac_host_model.sv ----
`timescale 1ns/1ps
// Host side: link clock, serial data and latch; the clock stands still between transfers
module dac_host_model
(
  output logic      link_clk_o,
  output logic      data_o,
  output logic      latch_o,
  input  wire logic data_out_i
);
  logic [15:0] seen;

  // Idle line is high
  initial
  begin
    link_clk_o = 1'h0;
    data_o     = 1'h1;
    latch_o    = 1'h0;
  end

  // Data only moves while the clock is low, well clear of the sampling edge
  task automatic tick(input int n);
    repeat (n)
    begin
      #6 link_clk_o = 1'h1;
      #6 link_clk_o = 1'h0;
    end
  endtask

  // Start 0, sixteen bits top first, stop bit; each cell sixteen clocks
  task automatic send_async(input logic [15:0] w, input logic stop);
    logic [17:0] f;
    f = {1'h0, w, stop};
    for (int i = 17; i >= 0; i--)
    begin
      data_o = f[i];
      tick(16);
    end
    data_o = 1'h1; // Back to idle high
    tick(3);
  endtask

  // Shifts a word top first, recording the chained output before each edge
  task automatic shift3(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      data_o  = w[i];
      seen[i] = data_out_i;
      tick(1);
    end
    data_o = ~w[0]; // Line released: never shows the last bit
  endtask

  // Held high selects asynchronous mode; a rise loads in three-wire mode
  task automatic set_latch(input logic v);
    latch_o = v;
    #40;
  endtask
endmodule

// ---- bench/dac_serial_async_receiver_bench.sv ----
`timescale 1ns/1ps
module dac_serial_async_receiver_bench;
  logic                   sys_clk_i;
  logic                   rst_n_i;
  logic                   clear_i;
  logic                   range_sel2_i;
  logic                   range_sel1_i;
  wire logic              link_clk;
  wire logic              data_in;
  wire logic              latch;
  wire logic              data_out;
  wire logic [15:0]       dac_code;
  wire dac_serial_pkg::range_t range;
  wire logic              dac_update;
  wire logic              at_bottom;
  int                     n_mismatch = 0;
  int                     checked = 0;
  int                     n_upd = 0;
  int                     n_ferr = 0;

  dac_serial_async_receiver dut
  (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .link_clk_i   (link_clk),
    .data_i       (data_in),
    .latch_i      (latch),
    .clear_i      (clear_i),
    .range_sel2_i (range_sel2_i),
    .range_sel1_i (range_sel1_i),
    .data_out_o   (data_out),
    .dac_code_o   (dac_code),
    .range_o      (range),
    .dac_update_o (dac_update),
    .at_bottom_o  (at_bottom)
  );

  dac_host_model host
  (
    .link_clk_o (link_clk),
    .data_o     (data_in),
    .latch_o    (latch),
    .data_out_i (data_out)
  );

  // Core clock, 5 ns period
  initial
  begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Pulses are counted where sampled, so a two-cycle pulse counts twice
  always @(posedge sys_clk_i)
    if (dac_update === 1'h1)
      n_upd++;
  always @(posedge link_clk)
    if (data_out === 1'h1 && latch === 1'h1)
      n_ferr++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One asynchronous frame, then code, update count and error pulse count
  task automatic frame(input logic [15:0] w, input logic stop, input logic [15:0] exp,
                       input int du, input int df);
    int u0;
    int f0;
    u0 = n_upd;
    f0 = n_ferr;
    host.send_async(w, stop);
    settle(12);
    check("code", dac_code, exp);
    check("updates", 16'(n_upd - u0), 16'(du));
    check("error pulses", 16'(n_ferr - f0), 16'(df));
  endtask

  // Whole run is about 19 us; a hang is cut well beyond that
  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    rst_n_i      = 1'h0;
    clear_i      = 1'h0;
    range_sel2_i = 1'h0;
    range_sel1_i = 1'h0;
    host.tick(3);
    settle(3);
    rst_n_i <= 1'h1;
    settle(1);
    check("code", dac_code, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk_i);
      {range_sel2_i, range_sel1_i} <= i[1:0];
      settle(6);
      check("range", {14'h0000, range}, 16'(i));
    end
    // Asynchronous frames: good, bad stop, good back to back
    host.set_latch(1'h1);
    host.tick(4);
    frame(16'hA5C3, 1'h1, 16'hA5C3, 1, 0);
    frame(16'h1234, 1'h0, 16'hA5C3, 0, 1);
    frame(16'h8001, 1'h1, 16'h8001, 1, 0);
    // Clear forces bottom, holds through an update and after release
    @(posedge sys_clk_i);
    clear_i <= 1'h1;
    settle(6);
    check("bottom", {15'h0000, at_bottom}, 16'h0001);
    check("code", dac_code, 16'h0000);
    host.send_async(16'h7FFF, 1'h1);
    settle(12);
    check("code", dac_code, 16'h0000);
    @(posedge sys_clk_i);
    clear_i <= 1'h0;
    settle(6);
    check("code", dac_code, 16'h0000);
    frame(16'h0F0F, 1'h1, 16'h0F0F, 1, 0);
    check("bottom", {15'h0000, at_bottom}, 16'h0000);
    // Three-wire: chain out the first word, load the second on the latch rise
    host.set_latch(1'h0);
    host.tick(3);
    host.shift3(16'hC35A);
    host.shift3(16'h3C96);
    check("chain out", host.seen, 16'hC35A);
    host.set_latch(1'h1);
    settle(4);
    check("code", dac_code, 16'h3C96);
    close_out();
  end
endmodule

// ---- rtl/dac_link_if.sv ----
`timescale 1ns/1ps
// Words and events handed from the link domain to the core domain
interface dac_link_if;
  logic [15:0] word;
  logic        word_tog;
  logic [15:0] shift_word;

  modport link
  (
    output word,
    output word_tog,
    output shift_word
  );

  modport core
  (
    input word,
    input word_tog,
    input shift_word
  );
endinterface

// ---- rtl/dac_link_rx.sv ----
`timescale 1ns/1ps
`include "dac_serial_map.svh"

module dac_link_rx
(
  input  wire logic  link_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  data_i,
  input  wire logic  latch_i,
  output wire logic  data_out_o,
  dac_link_if.link   lnk
);

  dac_serial_pkg::rx_state_t state_ff;
  dac_serial_pkg::rx_state_t nxt_state;
  logic [8:0]                cnt_ff;
  logic [8:0]                nxt_cnt;
  logic [15:0]               shift_ff;
  logic [15:0]               nxt_shift;
  logic [15:0]               word_ff;
  logic [15:0]               nxt_word;
  logic                      tog_ff;
  logic                      nxt_tog;
  logic                      dout_ff;
  logic                      nxt_dout;
  logic                      mode_s1_ff;
  logic                      async_ff;
  logic                      line_ff;
  logic                      nxt_line;

  // True on the clocks that fall in the centre of a data cell
  function automatic logic is_sample(input logic [8:0] c);
    logic [8:0] off;
    off = c - `RX_FIRST_SAMPLE;
    is_sample = (c >= `RX_FIRST_SAMPLE) && (c <= `RX_LAST_SAMPLE) &&
                ((off & (`RX_CELL_CLKS - 9'h001)) == 9'h000);
  endfunction

  // Latch level decides the mode; it is a pin, so it is synchronised first
  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_s1_ff <= 1'b0;
      async_ff   <= 1'b0;
    end
    else
    begin
      mode_s1_ff <= latch_i;
      async_ff   <= mode_s1_ff;
    end
  end

  // Data is launched against this clock, so it is sampled without a synchroniser
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_shift = shift_ff;
    nxt_word  = word_ff;
    nxt_tog   = tog_ff;
    nxt_dout  = 1'b0;
    nxt_line  = data_i;
    if (!async_ff)
    begin
      nxt_state = dac_serial_pkg::RX_IDLE;
      nxt_cnt   = `RX_CNT_IDLE;
      nxt_shift = {shift_ff[14:0], data_i};
      nxt_dout  = shift_ff[14];
    end
    else
    begin
      case (state_ff)
        dac_serial_pkg::RX_IDLE:
        begin
          // First clock after a high-to-low step is clock zero of the frame;
          // a stop cell still low after a framing error is not a new start
          if (line_ff && !data_i)
          begin
            nxt_state = dac_serial_pkg::RX_RECV;
            nxt_cnt   = `RX_CNT_START;
          end
        end
        dac_serial_pkg::RX_RECV:
        begin
          nxt_cnt = cnt_ff + `RX_CNT_START;
          if (is_sample(cnt_ff))
          begin
            nxt_shift = {shift_ff[14:0], data_i};
          end
          if (cnt_ff == `RX_STOP_SAMPLE)
          begin
            nxt_state = dac_serial_pkg::RX_IDLE;
            nxt_cnt   = `RX_CNT_IDLE;
            if (data_i)
            begin
              nxt_word = shift_ff;
              nxt_tog  = ~tog_ff;
            end
            else
            begin
              nxt_dout = 1'b1;
            end
          end
        end
        default:
        begin
          nxt_state = dac_serial_pkg::RX_IDLE;
          nxt_cnt   = `RX_CNT_IDLE;
        end
      endcase
    end
  end

  // Receiver registers
  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= dac_serial_pkg::RX_IDLE;
      cnt_ff   <= `RX_CNT_IDLE;
      shift_ff <= `DAC_RESET_WORD;
      word_ff  <= `DAC_RESET_WORD;
      tog_ff   <= 1'b0;
      dout_ff  <= 1'b0;
      line_ff  <= 1'b1;
    end
    else
    begin
      line_ff  <= nxt_line;
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
      word_ff  <= nxt_word;
      tog_ff   <= nxt_tog;
      dout_ff  <= nxt_dout;
    end
  end

  assign data_out_o     = dout_ff;
  assign lnk.word       = word_ff;
  assign lnk.word_tog   = tog_ff;
  assign lnk.shift_word = shift_ff;

  property p_start;
    @(posedge link_clk_i) disable iff (!rst_n_i)
    async_ff && state_ff == dac_serial_pkg::RX_IDLE && line_ff && !data_i
    |=> state_ff == dac_serial_pkg::RX_RECV && cnt_ff == `RX_CNT_START;
  endproperty
  a_start: assert property (p_start)
    else $error("start bit did not open a frame");

  property p_sample;
    @(posedge link_clk_i) disable iff (!rst_n_i)
    async_ff && state_ff == dac_serial_pkg::RX_RECV && is_sample(cnt_ff)
    |=> shift_ff[0] == $past(data_i) && shift_ff[15:1] == $past(shift_ff[14:0]);
  endproperty
  a_sample: assert property (p_sample)
    else $error("data bit not taken at cell centre");

  property p_ferr;
    @(posedge link_clk_i) disable iff (!rst_n_i)
    async_ff && state_ff == dac_serial_pkg::RX_RECV && cnt_ff == `RX_STOP_SAMPLE
    && !data_i |=> dout_ff && tog_ff == $past(tog_ff) ##1 !dout_ff;
  endproperty
  a_ferr: assert property (p_ferr)
    else $error("framing error pulse wrong or word kept");

  property p_good;
    @(posedge link_clk_i) disable iff (!rst_n_i)
    async_ff && state_ff == dac_serial_pkg::RX_RECV && cnt_ff == `RX_STOP_SAMPLE
    && data_i |=> !dout_ff && tog_ff != $past(tog_ff) && word_ff == $past(shift_ff);
  endproperty
  a_good: assert property (p_good)
    else $error("good frame not handed over");

  property p_chain;
    @(posedge link_clk_i) disable iff (!rst_n_i)
    !async_ff |=> dout_ff == $past(shift_ff[14]);
  endproperty
  a_chain: assert property (p_chain)
    else $error("daisy chain output wrong");

endmodule

// ---- rtl/dac_serial_async_receiver.sv ----
`timescale 1ns/1ps
`include "dac_serial_map.svh"

module dac_serial_async_receiver
(
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    link_clk_i,
  input  wire logic                    data_i,
  input  wire logic                    latch_i,
  input  wire logic                    clear_i,
  input  wire logic                    range_sel2_i,
  input  wire logic                    range_sel1_i,
  output wire logic                    data_out_o,
  output wire logic [15:0]             dac_code_o,
  output wire dac_serial_pkg::range_t  range_o,
  output wire logic                    dac_update_o,
  output wire logic                    at_bottom_o
);

  logic [4:0]             s1_ff;
  logic [4:0]             s2_ff;
  logic [1:0]             s3_ff;
  logic [4:0]             nxt_s1;
  logic [4:0]             nxt_s2;
  logic [1:0]             nxt_s3;
  logic                   latch_rise;
  logic                   tog_evt;
  logic                   clr;
  logic                   upd;
  logic [15:0]            dac_ff;
  logic [15:0]            nxt_dac;
  logic                   hold_ff;
  logic                   nxt_hold;
  logic [15:0]            code_ff;
  logic [15:0]            nxt_code;
  logic                   upd_ff;
  logic                   nxt_upd;
  logic                   bottom_ff;
  logic                   nxt_bottom;
  dac_serial_pkg::range_t range_ff;
  dac_serial_pkg::range_t nxt_range;

  dac_link_if lnk ();

  // Link-side logic runs on the host clock
  dac_link_rx u_rx
  (
    .link_clk_i (link_clk_i),
    .rst_n_i    (rst_n_i),
    .data_i     (data_i),
    .latch_i    (latch_i),
    .data_out_o (data_out_o),
    .lnk        (lnk)
  );

  // Pins and the word toggle enter this domain through two flops each
  always_comb
  begin
    nxt_s1 = {latch_i, clear_i, range_sel2_i, range_sel1_i, lnk.word_tog};
    nxt_s2 = s1_ff;
    nxt_s3 = {s2_ff[`SY_LATCH], s2_ff[`SY_TOG]};
  end

  // Latch resets high so a tied-high latch never looks like a rising edge
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_ff <= `SYNC_RST;
      s2_ff <= `SYNC_RST;
      s3_ff <= 2'h2;
    end
    else
    begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
    end
  end

  // Events seen from the synchronised copies only
  assign latch_rise = s2_ff[`SY_LATCH] & ~s3_ff[1];
  assign tog_evt    = s2_ff[`SY_TOG] ^ s3_ff[0];
  assign clr        = s2_ff[`SY_CLEAR];
  assign upd        = tog_evt | latch_rise;

  // Converter register, clear hold and output code
  always_comb
  begin
    nxt_dac = dac_ff;
    if (tog_evt)
    begin
      // Word was written with its toggle and holds for a full frame, so it is steady here
      nxt_dac = lnk.word;
    end
    else if (latch_rise)
    begin
      // Shifter is quiet while latch rises, host clock stops before latch
      nxt_dac = lnk.shift_word;
    end
    if (clr)
    begin
      nxt_hold = 1'b1;
    end
    else if (upd)
    begin
      nxt_hold = 1'b0;
    end
    else
    begin
      nxt_hold = hold_ff;
    end
    // Clear never touches the stored word, only the code sent to the converter
    nxt_code   = (clr || nxt_hold) ? `DAC_BOTTOM_CODE : nxt_dac;
    nxt_bottom = clr || nxt_hold;
    nxt_upd    = upd;
  end

  // Range decode, first bit is range select 2
  always_comb
  begin
    case ({s2_ff[`SY_RS2], s2_ff[`SY_RS1]})
      2'h0:    nxt_range = dac_serial_pkg::RANGE_V0_5;
      2'h1:    nxt_range = dac_serial_pkg::RANGE_I4_20;
      2'h2:    nxt_range = dac_serial_pkg::RANGE_I0_20;
      2'h3:    nxt_range = dac_serial_pkg::RANGE_I0_24;
      default: nxt_range = dac_serial_pkg::RANGE_V0_5;
    endcase
  end

  // Power-up leaves the output at the bottom of the span
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dac_ff    <= `DAC_RESET_WORD;
      hold_ff   <= 1'b0;
      code_ff   <= `DAC_BOTTOM_CODE;
      upd_ff    <= 1'b0;
      bottom_ff <= 1'b0;
      range_ff  <= dac_serial_pkg::RANGE_V0_5;
    end
    else
    begin
      dac_ff    <= nxt_dac;
      hold_ff   <= nxt_hold;
      code_ff   <= nxt_code;
      upd_ff    <= nxt_upd;
      bottom_ff <= nxt_bottom;
      range_ff  <= nxt_range;
    end
  end

  assign dac_code_o   = code_ff;
  assign range_o      = range_ff;
  assign dac_update_o = upd_ff;
  assign at_bottom_o  = bottom_ff;

  property p_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clr |=> code_ff == `DAC_BOTTOM_CODE && bottom_ff;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not force bottom code");

  property p_clear_keeps;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clr && !upd |=> dac_ff == $past(dac_ff);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("clear altered stored word");

  property p_stay_bottom;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(clr) && !upd ##1 !clr && !upd [*3]
    |-> code_ff == `DAC_BOTTOM_CODE;
  endproperty
  a_stay_bottom: assert property (p_stay_bottom)
    else $error("output left bottom without update");

  property p_latch_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    latch_rise && !tog_evt |=> dac_ff == $past(lnk.shift_word);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch edge did not load shifted word");

  property p_word_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    tog_evt && !clr && !hold_ff |=> dac_ff == $past(lnk.word) && upd_ff
    && code_ff == $past(lnk.word);
  endproperty
  a_word_load: assert property (p_word_load)
    else $error("received word not sent to output");

  property p_no_upd;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !upd |=> dac_ff == $past(dac_ff) && !upd_ff;
  endproperty
  a_no_upd: assert property (p_no_upd)
    else $error("output changed without an update");

  property p_range;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s2_ff[`SY_RS2] && !s2_ff[`SY_RS1] |=> range_ff == dac_serial_pkg::RANGE_I0_20;
  endproperty
  a_range: assert property (p_range)
    else $error("range decode wrong");

endmodule

// ---- rtl/dac_serial_map.svh ----
`ifndef DAC_SERIAL_MAP_SVH
`define DAC_SERIAL_MAP_SVH

// Receive timing, in link clock periods counted from the start-bit clock
`define RX_CELL_CLKS    9'h010
`define RX_FIRST_SAMPLE 9'h018
`define RX_LATER_BITS   9'h00F
`define RX_LAST_SAMPLE  (`RX_FIRST_SAMPLE + `RX_CELL_CLKS * `RX_LATER_BITS)
`define RX_STOP_SAMPLE  (`RX_LAST_SAMPLE + `RX_CELL_CLKS)
`define RX_CNT_START    9'h001
`define RX_CNT_IDLE     9'h000

// Output code and reset values
`define DAC_BOTTOM_CODE 16'h0000
`define DAC_RESET_WORD  16'h0000

// Bit positions in the pin synchroniser vector
`define SY_LATCH 4
`define SY_CLEAR 3
`define SY_RS2   2
`define SY_RS1   1
`define SY_TOG   0
`define SYNC_RST 5'h10

`endif

// ---- rtl/dac_serial_pkg.sv ----
package dac_serial_pkg;

  // Output span selected by the two range pins
  typedef enum logic [1:0]
  {
    RANGE_V0_5  = 2'h0,
    RANGE_I4_20 = 2'h1,
    RANGE_I0_20 = 2'h2,
    RANGE_I0_24 = 2'h3
  } range_t;

  // Asynchronous receiver states
  typedef enum logic
  {
    RX_IDLE = 1'h0,
    RX_RECV = 1'h1
  } rx_state_t;

endpackage
